// >>> verilog/lj_pkg.sv
/*
  Shared constants and types for one line-interface channel: the LOS
  timers, the elastic store sizes and the small register map.
  Assumes a single 100 MHz core clock; all line clocks arrive as pins.
*/
package lj_pkg;
  // ----------------------------------------------------------------
  // register map (byte-wide, plain strobe port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM = 8'h03;
  localparam logic [7:0] ADDR_CHAN = 8'h06;
  localparam logic [7:0] ADDR_RXCTL = 8'h05;
  localparam logic [7:0] ADDR_JACTL = 8'h07;
  // alarm status bits
  localparam int BIT_DIGITAL_SIGNAL_LOSS = 5;
  localparam int BIT_ANALOG_SIGNAL_LOSS = 4;
  localparam int BIT_FL = 3;
  localparam int BIT_COMBINED_SIGNAL_LOSS = 1;
  // receive control bits
  localparam int BIT_DDIS = 5;
  localparam int BIT_ADIS = 4;
  localparam int BIT_MUTE = 2;
  // channel control bits
  localparam int BIT_E3 = 2;
  // attenuator control bits
  localparam int BIT_JRST = 3;
  localparam int BIT_SEL1 = 2;
  localparam int BIT_PATH = 1;
  localparam int BIT_SEL0 = 0;
  localparam logic [7:0] RXCTL_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] JACTL_RST = 8'h00;
  // ----------------------------------------------------------------
  // loss timers, in line unit intervals
  // ----------------------------------------------------------------
  localparam logic [7:0] E3_DECLARE_UI = 8'h20;
  localparam logic [7:0] E3_CLEAR_UI = 8'h20;
  localparam logic [7:0] DIGITAL_SIGNAL_LOSS_ZEROS = 8'haf;
  localparam logic [7:0] DIGITAL_SIGNAL_LOSS_WINDOW = 8'haf;
  localparam logic [7:0] DIGITAL_SIGNAL_LOSS_ONES_MIN = 8'h3a;
  // ----------------------------------------------------------------
  // elastic store
  // ----------------------------------------------------------------
  localparam int FIFO_AW = 5;
  localparam logic [5:0] DEPTH_SMALL = 6'h10;
  localparam logic [5:0] DEPTH_LARGE = 6'h20;
  localparam logic [5:0] NEAR_LIMIT = 6'h02;
  // attenuator mode codes {sel1, sel0}
  localparam logic [1:0] JA_OFF = 2'h0;
  localparam logic [1:0] JA_SMALL = 2'h1;

  typedef struct packed {
    logic rx_clk;
    logic ref_clk;
    logic rate_clk;
    logic tx_clk;
    logic dj_clk;
    logic rpos;
    logic rneg;
    logic tpos;
    logic tneg;
    logic analog_low;
    logic mute_pin;
    logic path_pin;
    logic sel_pin1;
    logic sel_pin0;
    logic e3_pin;
    logic single_rate_clock_mode;
  } lj_pins_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } lj_rail_t;
endpackage

// >>> verilog/lj_fifo.sv
/*
  Elastic store of the jitter attenuator: 2-bit rail pairs, depth 16
  or 32. Assumes write and read arrive as one-cycle enables on clk_in.
*/
`timescale 1ns/1ps
module lj_fifo import lj_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic deep_in,
  input wire logic clear_in,
  // write side
  input wire logic wr_in,
  input wire lj_rail_t wdata_in,
  // read side
  input wire logic rd_in,
  output lj_rail_t rdata_out,
  // status
  output logic near_out
);
  lj_rail_t mem [0:31];
  logic [FIFO_AW-1:0] wp_r;
  logic [FIFO_AW-1:0] rp_r;
  logic [5:0] cnt_r;
  lj_rail_t rdata_r;

  function automatic logic [FIFO_AW-1:0] wrap(input logic [FIFO_AW-1:0] a,
                                             input logic deep);
    wrap = deep ? a : (a & 5'h0f);
  endfunction

  wire [5:0] depth = deep_in ? DEPTH_LARGE : DEPTH_SMALL;
  wire [5:0] half = {1'b0, depth[5:1]};
  wire do_wr = wr_in && (cnt_r != depth);
  wire do_rd = rd_in && (cnt_r != 6'h00);
  wire [5:0] cnt_nxt = cnt_r + {5'h00, do_wr} - {5'h00, do_rd};

  // near either end: lets software re-centre before a slip
  assign near_out = (cnt_r <= NEAR_LIMIT) ||
                    (cnt_r >= depth - NEAR_LIMIT);
  assign rdata_out = rdata_r;

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wp_r] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_r <= 5'h00;
      rp_r <= wrap(5'h00 - half[FIFO_AW-1:0], deep_in);
      cnt_r <= half;
    end else if (clear_in) begin
      // restart half full so both margins are equal
      // pointers folded into the new depth so no write lands outside it
      wp_r <= wrap(wp_r, deep_in);
      rp_r <= wrap(wp_r - half[FIFO_AW-1:0], deep_in);
      cnt_r <= half;
    end else begin
      if (do_wr) begin
        wp_r <= wrap(wp_r + 5'h01, deep_in);
      end
      if (do_rd) begin
        rp_r <= wrap(rp_r + 5'h01, deep_in);
      end
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= '0;
    end else if (do_rd) begin
      rdata_r <= mem[rp_r];
    end
  end

  property p_clear_half;
    @(posedge clk_in) disable iff (rst_in)
      clear_in |=> (cnt_r == $past(half));
  endproperty
  a_clear_half: assert property (p_clear_half)
    else $error("store not re-centred after clear");
endmodule

// >>> verilog/lj_channel.sv
/*
  One channel of the line interface: LOS declare and clear, recovered
  clock selection, data muting and the jitter attenuator around the
  elastic store. Assumes every line-side signal is an asynchronous pin
  much slower than clk_in, and software on a byte-wide strobe port.
*/
`timescale 1ns/1ps
module lj_channel import lj_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // asynchronous pins
  input wire lj_pins_t pins_in,
  input wire logic host_mode_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // receive side towards framer
  output logic recovered_clock_out,
  output lj_rail_t rx_rail_out,
  // transmit side towards line driver
  output logic tx_clock_out,
  output lj_rail_t tx_rail_out,
  // alarm
  output logic alarm_n_out
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  lj_pins_t meta_r;
  lj_pins_t pin_r;
  logic rec_clk_r;
  logic tx_clk_r;
  logic dj_clk_r;
  logic host_meta_r;
  logic host_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      pin_r <= '0;
      host_meta_r <= 1'b0;
      host_r <= 1'b0;
    end else begin
      meta_r <= pins_in;
      pin_r <= meta_r;
      host_meta_r <= host_mode_in;
      host_r <= host_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] rxctl_r;
  logic [7:0] chan_r;
  logic [7:0] jactl_r;
  logic [7:0] rdata_r;
  logic fl_r;
  logic digital_signal_loss_r;
  logic analog_signal_loss_r;

  wire wr_rx = reg_wr_in && (reg_addr_in == ADDR_RXCTL);
  wire wr_ch = reg_wr_in && (reg_addr_in == ADDR_CHAN);
  wire wr_ja = reg_wr_in && (reg_addr_in == ADDR_JACTL);
  wire rd_alarm = reg_rd_in && (reg_addr_in == ADDR_ALARM);
  wire ja_reset = wr_ja && reg_wdata_in[BIT_JRST];
  wire los = digital_signal_loss_r || analog_signal_loss_r;
  wire [7:0] alarm_word = (8'h01 << BIT_DIGITAL_SIGNAL_LOSS) & {8{digital_signal_loss_r}} |
                          (8'h01 << BIT_ANALOG_SIGNAL_LOSS) & {8{analog_signal_loss_r}} |
                          (8'h01 << BIT_FL) & {8{fl_r}} |
                          (8'h01 << BIT_COMBINED_SIGNAL_LOSS) & {8{los}};
  wire [7:0] rd_mux = (reg_addr_in == ADDR_ALARM) ? alarm_word :
                      (reg_addr_in == ADDR_RXCTL) ? rxctl_r :
                      (reg_addr_in == ADDR_CHAN) ? chan_r :
                      (reg_addr_in == ADDR_JACTL) ?
                        (jactl_r & 8'h07) : 8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rxctl_r <= RXCTL_RST;
      chan_r <= CHAN_RST;
      jactl_r <= JACTL_RST;
      rdata_r <= 8'h00;
    end else begin
      if (wr_rx) begin
        rxctl_r <= reg_wdata_in;
      end
      if (wr_ch) begin
        chan_r <= reg_wdata_in;
      end
      if (wr_ja) begin
        jactl_r <= reg_wdata_in;
      end
      rdata_r <= reg_rd_in ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------
  // mode selection: host bits or shared pins
  // ----------------------------------------------------------------
  wire los_off = rxctl_r[BIT_ADIS] && rxctl_r[BIT_DDIS];
  wire e3_mode = host_r ? chan_r[BIT_E3] : pin_r.e3_pin;
  wire mute_en = host_r ? rxctl_r[BIT_MUTE] : pin_r.mute_pin;
  wire path_tx = host_r ? jactl_r[BIT_PATH] : pin_r.path_pin;
  wire [1:0] ja_mode = host_r ? {jactl_r[BIT_SEL1], jactl_r[BIT_SEL0]} :
                                {pin_r.sel_pin1, pin_r.sel_pin0};
  wire ja_on = (ja_mode != JA_OFF);
  wire ja_deep = ja_on && (ja_mode != JA_SMALL);

  // ----------------------------------------------------------------
  // recovered clock: line, reference or rate clock
  // ----------------------------------------------------------------
  wire rec_sel = !los ? pin_r.rx_clk :
                 pin_r.single_rate_clock_mode ? pin_r.rate_clk : pin_r.ref_clk;
  wire rec_tick = rec_sel && !rec_clk_r;
  wire tx_tick = pin_r.tx_clk && !tx_clk_r;
  wire dj_tick = pin_r.dj_clk && !dj_clk_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rec_clk_r <= 1'b0;
      tx_clk_r <= 1'b0;
      dj_clk_r <= 1'b0;
    end else begin
      rec_clk_r <= rec_sel;
      tx_clk_r <= pin_r.tx_clk;
      dj_clk_r <= pin_r.dj_clk;
    end
  end

  // ----------------------------------------------------------------
  // loss detection, counted in recovered-clock periods, except analog loss outside E3 mode, which follows analog_low directly
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_r;
  logic [7:0] zero_cnt_r;
  logic [7:0] win_cnt_r;
  logic [7:0] ones_cnt_r;
  wire mark = pin_r.rpos || pin_r.rneg;
  wire win_end = (win_cnt_r == DIGITAL_SIGNAL_LOSS_WINDOW - 8'h01);

  // one counter serves both directions: it runs while the level
  // disagrees with the present state and restarts otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in || los_off) begin
      analog_signal_loss_r <= 1'b0;
      low_cnt_r <= 8'h00;
    end else if (!e3_mode) begin
      analog_signal_loss_r <= pin_r.analog_low;
      low_cnt_r <= 8'h00;
    end else if (rec_tick) begin
      if (pin_r.analog_low == analog_signal_loss_r) begin
        low_cnt_r <= 8'h00;
      end else if (low_cnt_r ==
                   (analog_signal_loss_r ? E3_CLEAR_UI : E3_DECLARE_UI) - 8'h01) begin
        analog_signal_loss_r <= !analog_signal_loss_r;
        low_cnt_r <= 8'h00;
      end else begin
        low_cnt_r <= low_cnt_r + 8'h01;
      end
    end
  end

  // clears once a full window shows at least 58 marks
  always_ff @(posedge clk_in) begin
    if (rst_in || los_off || e3_mode) begin
      digital_signal_loss_r <= 1'b0;
      zero_cnt_r <= 8'h00;
      win_cnt_r <= 8'h00;
      ones_cnt_r <= 8'h00;
    end else if (rec_tick) begin
      if (!digital_signal_loss_r) begin
        zero_cnt_r <= mark ? 8'h00 : zero_cnt_r + 8'h01;
        if (!mark && zero_cnt_r == DIGITAL_SIGNAL_LOSS_ZEROS - 8'h01) begin
          digital_signal_loss_r <= 1'b1;
        end
      end else begin
        zero_cnt_r <= 8'h00;
        win_cnt_r <= win_end ? 8'h00 : win_cnt_r + 8'h01;
        ones_cnt_r <= win_end ? 8'h00 : ones_cnt_r + {7'h00, mark};
        if (win_end && ones_cnt_r >= DIGITAL_SIGNAL_LOSS_ONES_MIN) begin
          digital_signal_loss_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // jitter attenuator
  // ----------------------------------------------------------------
  lj_rail_t rx_in;
  lj_rail_t tx_in;
  lj_rail_t fifo_q;
  logic near;
  assign rx_in = '{pos: pin_r.rpos, neg: pin_r.rneg};
  assign tx_in = '{pos: pin_r.tpos, neg: pin_r.tneg};
  wire fifo_clear = rd_alarm || ja_reset || !ja_on;
  wire fifo_wr = ja_on && (path_tx ? tx_tick : rec_tick);

  lj_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .deep_in(ja_deep),
    .clear_in(fifo_clear),
    .wr_in(fifo_wr),
    .wdata_in(path_tx ? tx_in : rx_in),
    .rd_in(dj_tick),
    .rdata_out(fifo_q),
    .near_out(near)
  );

  // a new near event wins over the read that clears the flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fl_r <= 1'b0;
    end else begin
      fl_r <= (ja_on && near) || (fl_r && !rd_alarm);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic rec_out_r;
  logic tx_ck_r;
  logic alarm_n_r;
  lj_rail_t rx_r;
  lj_rail_t tx_r;
  wire rx_via_ja = ja_on && !path_tx;
  wire tx_via_ja = ja_on && path_tx;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rec_out_r <= 1'b0;
      tx_ck_r <= 1'b0;
      rx_r <= '0;
      tx_r <= '0;
      alarm_n_r <= 1'b1;
    end else begin
      rec_out_r <= rx_via_ja ? pin_r.dj_clk : rec_sel;
      tx_ck_r <= tx_via_ja ? pin_r.dj_clk : pin_r.tx_clk;
      if (los && mute_en) begin
        rx_r <= '0;
      end else if (rx_via_ja ? dj_tick : rec_tick) begin
        rx_r <= rx_via_ja ? fifo_q : rx_in;
      end
      if (tx_via_ja ? dj_tick : tx_tick) begin
        tx_r <= tx_via_ja ? fifo_q : tx_in;
      end
      alarm_n_r <= !(los || fl_r);
    end
  end
  assign recovered_clock_out = rec_out_r;
  assign tx_clock_out = tx_ck_r;
  assign rx_rail_out = rx_r;
  assign tx_rail_out = tx_r;
  assign alarm_n_out = alarm_n_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_zero_last;
    rec_tick && !mark && !digital_signal_loss_r && zero_cnt_r == DIGITAL_SIGNAL_LOSS_ZEROS - 8'h01;
  endsequence
  sequence s_e3_low_last;
    e3_mode && rec_tick && pin_r.analog_low && !analog_signal_loss_r &&
      low_cnt_r == E3_DECLARE_UI - 8'h01;
  endsequence
  sequence s_e3_high_last;
    e3_mode && rec_tick && !pin_r.analog_low && analog_signal_loss_r &&
      low_cnt_r == E3_CLEAR_UI - 8'h01;
  endsequence

  property p_los_off;
    @(posedge clk_in) disable iff (rst_in)
      los_off |=> !los;
  endproperty
  a_los_off: assert property (p_los_off)
    else $error("loss reported while detection disabled");

  property p_e3_declare;
    @(posedge clk_in) disable iff (rst_in)
      (s_e3_low_last and !los_off && !wr_rx) |=> analog_signal_loss_r;
  endproperty
  a_e3_declare: assert property (p_e3_declare)
    else $error("E3 loss not declared after low run");

  property p_e3_clear;
    @(posedge clk_in) disable iff (rst_in)
      (s_e3_high_last and !wr_ch) |=> !analog_signal_loss_r;
  endproperty
  a_e3_clear: assert property (p_e3_clear)
    else $error("E3 loss not cleared after restore");

  property p_ref_clock;
    @(posedge clk_in) disable iff (rst_in)
      (los && !pin_r.single_rate_clock_mode && !rx_via_ja) |=>
        rec_out_r == $past(pin_r.ref_clk);
  endproperty
  a_ref_clock: assert property (p_ref_clock)
    else $error("recovered clock not on reference during loss");

  property p_rate_clock;
    @(posedge clk_in) disable iff (rst_in)
      (los && pin_r.single_rate_clock_mode && !rx_via_ja) |=>
        rec_out_r == $past(pin_r.rate_clk);
  endproperty
  a_rate_clock: assert property (p_rate_clock)
    else $error("recovered clock not on rate clock during loss");

  property p_mute;
    @(posedge clk_in) disable iff (rst_in)
      (los && mute_en) [*2] |-> rx_r == '0;
  endproperty
  a_mute: assert property (p_mute)
    else $error("rails not muted during loss");

  property p_flag_set;
    @(posedge clk_in) disable iff (rst_in)
      (ja_on && near) |=> fl_r ##1 !alarm_n_out;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("limit flag or alarm missing");

  property p_flag_read;
    @(posedge clk_in) disable iff (rst_in)
      (rd_alarm && !near) |=> !fl_r;
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("limit flag survived its read");

  property p_digital_signal_loss;
    @(posedge clk_in) disable iff (rst_in)
      (s_zero_last and !los_off && !e3_mode && !wr_rx && !wr_ch)
        |=> digital_signal_loss_r ##1 !alarm_n_out;
  endproperty
  a_digital_signal_loss: assert property (p_digital_signal_loss)
    else $error("digital loss not declared after zero run");
endmodule

// >>> test/lj_framer_model.sv
/*
  Framer-side partner: counts rising edges of a line clock output and
  the marks on the rail pair sampled at each of those edges.
  Assumes the watched clock output is registered on clk_in.
*/
`timescale 1ns/1ps
module lj_framer_model import lj_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched line side
  input wire logic line_clk_in,
  input wire lj_rail_t rail_in,
  input wire logic clear_in,
  // counts
  output logic [15:0] edges_out,
  output logic [15:0] marks_out
);
  // ----------------------------------------------------------------
  // edge and mark counters
  // ----------------------------------------------------------------
  logic clk_prev_r;
  logic rise;
  // rails are taken on the edge itself, as a framer latches them
  assign rise = line_clk_in & ~clk_prev_r;
  always_ff @(posedge clk_in) begin
    clk_prev_r <= line_clk_in;
    if (rst_in || clear_in) begin
      edges_out <= 16'h0000;
      marks_out <= 16'h0000;
    end else if (rise) begin
      edges_out <= edges_out + 16'h0001;
      if (rail_in.pos | rail_in.neg) begin
        marks_out <= marks_out + 16'h0001;
      end
    end
  end
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench for one line-interface channel: register port,
  loss declare and clear, muting, clock choice and elastic store.
  Assumes lj_channel and lj_framer_model are compiled before it.
*/
`timescale 1ns/1ps
module testbench import lj_pkg::*; ;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  lj_pins_t pins = '0;
  logic host_mode = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd;
  logic rec_clk, tx_clk_o, alarm_n;
  lj_rail_t rx_rail, tx_rail;
  // line clocks: rx, ref, rate, tx, dj; disabled ones stand low
  logic [4:0] clk_en = 5'h00;
  logic [1:0] ph = 2'h0;
  logic mdl_clr = 1'b0;
  logic [15:0] rx_edges, rx_marks, tx_edges, tx_marks;
  int n_mismatch = 0;
  int tests_run = 0;

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // 80 ns line period from four core cycles per half
  always @(posedge clk_in) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) begin
      pins.rx_clk <= clk_en[0] & ~pins.rx_clk;
      pins.ref_clk <= clk_en[1] & ~pins.ref_clk;
      pins.rate_clk <= clk_en[2] & ~pins.rate_clk;
      pins.tx_clk <= clk_en[3] & ~pins.tx_clk;
      pins.dj_clk <= clk_en[4] & ~pins.dj_clk;
    end
  end

  lj_channel lj_channel_inst (
    .clk_in(clk_in), .rst_in(rst_in), .pins_in(pins),
    .host_mode_in(host_mode), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .recovered_clock_out(rec_clk),
    .rx_rail_out(rx_rail), .tx_clock_out(tx_clk_o),
    .tx_rail_out(tx_rail), .alarm_n_out(alarm_n));
  lj_framer_model rx_mon (
    .clk_in(clk_in), .rst_in(rst_in), .line_clk_in(rec_clk),
    .rail_in(rx_rail), .clear_in(mdl_clr), .edges_out(rx_edges),
    .marks_out(rx_marks));
  lj_framer_model tx_mon (
    .clk_in(clk_in), .rst_in(rst_in), .line_clk_in(tx_clk_o),
    .rail_in(tx_rail), .clear_in(mdl_clr), .edges_out(tx_edges),
    .marks_out(tx_marks));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts carry a pipeline slack of a tick or two at each end
  task automatic rng(input logic [15:0] v, input int lo, input int hi);
    check(16'(v >= 16'(lo) && v <= 16'(hi)), 16'h0001);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic run(input logic [4:0] m, input int n);
    clk_en <= m;
    mdl_clr <= 1'b1;
    @(posedge clk_in);
    mdl_clr <= 1'b0;
    repeat (8 * n) @(posedge clk_in);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdr(ADDR_CHAN);
    check(16'(rd), 16'(CHAN_RST));
    rdr(ADDR_RXCTL);
    check(16'(rd), 16'(RXCTL_RST));
    wr(ADDR_JACTL, 8'h0d);
    rdr(ADDR_JACTL);
    check(16'(rd), 16'h0005);
    wr(ADDR_JACTL, JACTL_RST);
    wr(ADDR_ALARM, 8'hff);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h3a), 16'h0000);
    rdr(8'h10);
    check(16'(rd), 16'h0000);
  endtask

  task automatic t_ds3();
    run(5'h01, 95);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h3a), 16'h0000);
    check(16'(alarm_n), 16'h0001);
    run(5'h01, 160);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h22), 16'h0022);
    check(16'(alarm_n), 16'h0000);
    run(5'h02, 20);
    rng(rx_edges, 18, 22);
    run(5'h04, 20);
    rng(rx_edges, 0, 1);
    pins.single_rate_clock_mode <= 1'b1;
    run(5'h04, 20);
    rng(rx_edges, 18, 22);
    run(5'h02, 20);
    rng(rx_edges, 0, 1);
    pins.single_rate_clock_mode <= 1'b0;
    wr(ADDR_RXCTL, 8'h04);
    pins.rpos <= 1'b1;
    run(5'h02, 30);
    check(rx_marks, 16'h0000);
    rng(rx_edges, 28, 32);
    run(5'h03, 400);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h22), 16'h0000);
    run(5'h01, 20);
    rng(rx_marks, 18, 22);
    wr(ADDR_RXCTL, 8'h00);
    pins.analog_low <= 1'b1;
    run(5'h01, 4);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h32), 16'h0012);
    pins.analog_low <= 1'b0;
    run(5'h01, 4);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h32), 16'h0000);
  endtask

  task automatic t_dis();
    wr(ADDR_RXCTL, 8'h30);
    pins.rpos <= 1'b0;
    pins.analog_low <= 1'b1;
    run(5'h01, 260);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h32), 16'h0000);
    check(16'(alarm_n), 16'h0001);
    pins.analog_low <= 1'b0;
    pins.rpos <= 1'b1;
    pins.tpos <= 1'b1;
    wr(ADDR_RXCTL, 8'h00);
    run(5'h0b, 200);
    rng(tx_marks, 198, 202);
  endtask

  task automatic t_e3();
    wr(ADDR_CHAN, 8'h04);
    run(5'h03, 20);
    pins.analog_low <= 1'b1;
    run(5'h03, 9);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h02), 16'h0000);
    run(5'h03, 246);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h02), 16'h0002);
    pins.analog_low <= 1'b0;
    run(5'h03, 9);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h02), 16'h0002);
    run(5'h03, 246);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h02), 16'h0000);
    wr(ADDR_CHAN, 8'h00);
  endtask

  task automatic t_ja();
    logic [7:0] mode [2] = '{8'h01, 8'h04};
    int half;
    for (int i = 0; i < 2; i++) begin
      half = (i == 0) ? 8 : 16;
      // small depth first, as suits delay-sensitive traffic
      wr(ADDR_JACTL, mode[i]);
      rdr(ADDR_ALARM);
      run(5'h10, half - 4);
      check(16'(alarm_n), 16'h0001);
      rng(rx_edges, half - 6, half - 2);
      run(5'h10, 4);
      check(16'(alarm_n), 16'h0000);
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0008);
      // store still near in the read cycle: the set wins once more
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0008);
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0000);
      run(5'h01, half - 4);
      check(16'(alarm_n), 16'h0001);
      rng(rx_edges, 0, 1);
      run(5'h01, 4);
      check(16'(alarm_n), 16'h0000);
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0008);
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0008);
      rdr(ADDR_ALARM);
      check(16'(rd & 8'h08), 16'h0000);
    end
    wr(ADDR_JACTL, 8'h00);
    run(5'h01, 40);
    rdr(ADDR_ALARM);
    check(16'(rd & 8'h08), 16'h0000);
    wr(ADDR_JACTL, 8'h03);
    rdr(ADDR_ALARM);
    run(5'h10, 6);
    rng(tx_edges, 4, 8);
    run(5'h08, 6);
    rng(tx_edges, 0, 1);
    wr(ADDR_JACTL, 8'h00);
    host_mode <= 1'b0;
    pins.path_pin <= 1'b1;
    pins.sel_pin0 <= 1'b1;
    run(5'h10, 6);
    rng(tx_edges, 4, 8);
    pins.path_pin <= 1'b0;
    run(5'h10, 6);
    rng(rx_edges, 4, 8);
    rng(tx_edges, 0, 1);
    // hardware mute pin, attenuator bypassed
    pins.sel_pin0 <= 1'b0;
    pins.mute_pin <= 1'b1;
    pins.analog_low <= 1'b1;
    run(5'h00, 1);
    run(5'h03, 6);
    check(rx_marks, 16'h0000);
    rng(rx_edges, 4, 8);
    pins.analog_low <= 1'b0;
    run(5'h03, 6);
    rng(rx_marks, 4, 8);
    pins.mute_pin <= 1'b0;
    host_mode <= 1'b1;
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_regs();
    t_ds3();
    t_dis();
    t_e3();
    t_ja();
    close_out();
  end

  // whole run is about 15k cycles
  initial begin
    repeat (40000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
endmodule
